// *** tph_host_if.v ***
// Touch controller host interface: I2C target, interrupt, reset and mode sequencer
`timescale 1ns/1ps
`default_nettype none
`include "tph_defines.vh"

module tph_host_if #(
  parameter        CLK_HZ      = `TPH_CLK_HZ,
  parameter [6:0]  DEV_ADDR    = `TPH_I2C_ADDR,
  parameter        INIT_CYCLES = `TPH_INIT_MS * (`TPH_CLK_HZ / `TPH_MS_PER_S)
) (
  input  wire       i_sys_clk,
  input  wire       i_reset,
  input  wire       i_chip_reset_n,
  input  wire       i_scl,
  input  wire       i_sda,
  output reg        o_sda,
  output reg        o_sda_oe,
  output reg        o_int_n,
  input  wire       i_frame_done,
  input  wire       i_touch_found,
  input  wire [7:0] i_touch_data,
  output reg        o_scan_start,
  output reg        o_presence_only,
  output reg        o_power_down,
  output reg  [1:0] o_mode,
  output reg        o_cfg_wr,
  output reg  [3:0] o_cfg_addr,
  output reg  [7:0] o_cfg_data
);

  localparam [2:0] ST_IDLE  = 3'b000;
  localparam [2:0] ST_ADDR  = 3'b001;
  localparam [2:0] ST_AACK  = 3'b010;
  localparam [2:0] ST_WDATA = 3'b011;
  localparam [2:0] ST_WACK  = 3'b100;
  localparam [2:0] ST_RDATA = 3'b101;
  localparam [2:0] ST_RACK  = 3'b110;

  // Level accepted once the second and third stages agree
  function filt;
    input s2;
    input s3;
    input q;
    begin
      filt = (s2 == s3) ? s2 : q;
    end
  endfunction

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  reg [2:0] scl_sync;
  reg [2:0] sda_sync;
  reg [2:0] rst_sync;
  reg       scl_q;
  reg       sda_q;
  reg       scl_d;
  reg       sda_d;
  reg       rst_n_q;

  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      rst_sync <= 3'h0;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
      rst_n_q  <= 1'b0;
    end else begin
      scl_sync <= {scl_sync[1:0], i_scl};
      sda_sync <= {sda_sync[1:0], i_sda};
      rst_sync <= {rst_sync[1:0], i_chip_reset_n};
      scl_q    <= filt(scl_sync[1], scl_sync[2], scl_q);
      sda_q    <= filt(sda_sync[1], sda_sync[2], sda_q);
      rst_n_q  <= filt(rst_sync[1], rst_sync[2], rst_n_q);
      scl_d    <= scl_q;
      sda_d    <= sda_q;
    end
  end

  // Low level on the reset pin resets the I2C target and the sequencer; scan rates return to defaults, memory bytes and touch_byte keep their values
  wire soft_rst = ~rst_n_q;

  wire scl_rise = scl_q & ~scl_d;
  wire scl_fall = ~scl_q & scl_d;
  wire bus_start = scl_q & scl_d & sda_d & ~sda_q;
  wire bus_stop  = scl_q & scl_d & ~sda_d & sda_q;

  // ************************************************************
  // Shared state between the I2C target and the sequencer
  // ************************************************************
  reg  [7:0] touch_byte;
  reg        touch_read;
  wire [7:0] mem_rd;
  reg  [3:0] ptr;
  wire       if_open = (o_mode == `TPH_MODE_ACTIVE);

  tph_mem #(
    .AW (4),
    .DW (8)
  ) u_mem (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_wr_en   (o_cfg_wr),
    .i_wr_addr (o_cfg_addr),
    .i_wr_data (o_cfg_data),
    .i_rd_addr (ptr),
    .o_rd_data (mem_rd)
  );

  wire [7:0] rd_byte = (ptr == `TPH_REG_TOUCH) ? touch_byte : mem_rd;

  // ************************************************************
  // I2C target
  // ************************************************************
  reg [2:0] state;
  reg [7:0] sr;
  reg [7:0] tx;
  reg [3:0] bitcnt;
  reg       rw;
  reg       first;
  reg       host_ack;
  reg       sent_touch;

  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      state      <= ST_IDLE;
      sr         <= 8'h00;
      tx         <= 8'h00;
      bitcnt     <= 4'h0;
      rw         <= 1'b0;
      first      <= 1'b0;
      host_ack   <= 1'b0;
      sent_touch <= 1'b0;
      ptr        <= 4'h0;
      touch_read <= 1'b0;
      o_sda      <= 1'b0;
      o_sda_oe   <= 1'b0;
      o_cfg_wr   <= 1'b0;
      o_cfg_addr <= 4'h0;
      o_cfg_data <= 8'h00;
    end else if (soft_rst) begin
      state      <= ST_IDLE;
      bitcnt     <= 4'h0;
      ptr        <= 4'h0;
      touch_read <= 1'b0;
      o_sda_oe   <= 1'b0;
      o_cfg_wr   <= 1'b0;
    end else begin
      o_cfg_wr   <= 1'b0;
      touch_read <= 1'b0;
      o_sda      <= 1'b0;
      if (bus_start) begin
        // Start or repeated start ends any packet and opens a new one
        state    <= ST_ADDR;
        bitcnt   <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (bus_stop) begin
        state    <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            o_sda_oe <= 1'b0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              sr     <= {sr[6:0], sda_q};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == `TPH_BITS_BYTE) begin
              // Address in bits 7..1, direction in bit 0
              if (sr[7:1] == DEV_ADDR && if_open) begin
                o_sda_oe <= 1'b1;
                rw       <= sr[0];
                state    <= ST_AACK;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              if (rw) begin
                o_sda_oe   <= ~rd_byte[7];
                tx         <= {rd_byte[6:0], 1'b0};
                sent_touch <= (ptr == `TPH_REG_TOUCH);
                ptr        <= ptr + 4'h1;
                bitcnt     <= 4'h1;
                state      <= ST_RDATA;
              end else begin
                o_sda_oe <= 1'b0;
                first    <= 1'b1;
                bitcnt   <= 4'h0;
                state    <= ST_WDATA;
              end
            end
          end
          ST_WDATA: begin
            if (scl_rise) begin
              sr     <= {sr[6:0], sda_q};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == `TPH_BITS_BYTE) begin
              o_sda_oe <= 1'b1;
              first    <= 1'b0;
              if (first) begin
                ptr <= sr[3:0];
              end else begin
                // Parameter byte passed to the front end and stored
                o_cfg_wr   <= 1'b1;
                o_cfg_addr <= ptr;
                o_cfg_data <= sr;
                ptr        <= ptr + 4'h1;
              end
              state <= ST_WACK;
            end
          end
          ST_WACK: begin
            if (scl_fall) begin
              o_sda_oe <= 1'b0;
              bitcnt   <= 4'h0;
              state    <= ST_WDATA;
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              if (bitcnt == `TPH_BITS_BYTE) begin
                o_sda_oe <= 1'b0;
                state    <= ST_RACK;
              end else begin
                o_sda_oe <= ~tx[7];
                tx       <= {tx[6:0], 1'b0};
                bitcnt   <= bitcnt + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              host_ack   <= ~sda_q;
              // Touch byte fully delivered to the host
              touch_read <= sent_touch;
            end else if (scl_fall) begin
              if (host_ack) begin
                o_sda_oe   <= ~rd_byte[7];
                tx         <= {rd_byte[6:0], 1'b0};
                sent_touch <= (ptr == `TPH_REG_TOUCH);
                ptr        <= ptr + 4'h1;
                bitcnt     <= 4'h1;
                state      <= ST_RDATA;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            state    <= ST_IDLE;
            o_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Mode sequencer, frame timing and interrupt
  // ************************************************************
  reg  [31:0] init_cnt;
  reg         init_done;
  reg  [7:0]  act_rate;
  reg  [7:0]  mon_rate;
  reg  [31:0] acc;
  reg         data_ready;
  wire [7:0]  rate    = (o_mode == `TPH_MODE_MONITOR) ? mon_rate : act_rate;
  wire [31:0] acc_sum = acc + {24'h000000, rate};
  wire        tick    = (acc_sum >= CLK_HZ);
  wire        new_data = i_frame_done && i_touch_found && init_done &&
                         (o_mode == `TPH_MODE_ACTIVE);

  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      init_cnt        <= 32'h00000000;
      init_done       <= 1'b0;
      act_rate        <= `TPH_ACT_FPS;
      mon_rate        <= `TPH_MON_FPS;
      acc             <= 32'h00000000;
      data_ready      <= 1'b0;
      touch_byte      <= 8'h00;
      o_mode          <= `TPH_MODE_ACTIVE;
      o_int_n         <= 1'b1;
      o_scan_start    <= 1'b0;
      o_presence_only <= 1'b0;
      o_power_down    <= 1'b0;
    end else if (soft_rst) begin
      // Held in reset; wakes into active mode with defaults
      init_cnt        <= 32'h00000000;
      init_done       <= 1'b0;
      act_rate        <= `TPH_ACT_FPS;
      mon_rate        <= `TPH_MON_FPS;
      acc             <= 32'h00000000;
      data_ready      <= 1'b0;
      o_mode          <= `TPH_MODE_ACTIVE;
      o_int_n         <= 1'b1;
      o_scan_start    <= 1'b0;
      o_presence_only <= 1'b0;
      o_power_down    <= 1'b0;
    end else begin
      if (!init_done) begin
        if (init_cnt >= INIT_CYCLES - 1) begin
          init_done <= 1'b1;
        end else begin
          init_cnt <= init_cnt + 32'h00000001;
        end
      end
      if (o_mode == `TPH_MODE_HIBER) begin
        // Powered down: nothing but the reset pin acts
        acc          <= 32'h00000000;
        o_scan_start <= 1'b0;
      end else begin
        // Rate accumulator gives one frame per CLK_HZ / rate cycles
        acc          <= tick ? (acc_sum - CLK_HZ) : acc_sum;
        o_scan_start <= tick && init_done;
      end
      if (o_cfg_wr && o_mode != `TPH_MODE_HIBER) begin
        case (o_cfg_addr)
          `TPH_REG_MODE: begin
            if (o_cfg_data[1:0] != 2'h3) begin
              o_mode <= o_cfg_data[1:0];
            end
          end
          `TPH_REG_ACT_RATE: begin
            if (o_cfg_data != 8'h00) begin
              act_rate <= o_cfg_data;
            end
          end
          `TPH_REG_MON_RATE: begin
            if (o_cfg_data != 8'h00) begin
              mon_rate <= o_cfg_data;
            end
          end
          default: begin
            act_rate <= act_rate;
          end
        endcase
      end else if (o_mode == `TPH_MODE_MONITOR && i_frame_done && i_touch_found) begin
        o_mode <= `TPH_MODE_ACTIVE;
      end
      if (new_data) begin
        touch_byte <= i_touch_data;
      end
      // New data wins over a read that clears in the same cycle
      if (new_data) begin
        data_ready <= 1'b1;
      end else if (touch_read) begin
        data_ready <= 1'b0;
      end
      o_int_n         <= ~(data_ready && init_done);
      o_presence_only <= (o_mode == `TPH_MODE_MONITOR);
      o_power_down    <= (o_mode == `TPH_MODE_HIBER);
    end
  end

endmodule // tph_host_if

`default_nettype wire

// *** tph_defines.vh ***
// Shared constants of the touch host interface and mode control block
`ifndef TPH_DEFINES_VH
`define TPH_DEFINES_VH

// ************************************************************
// Clock and timing
// ************************************************************
`define TPH_CLK_HZ       100000000
`define TPH_MS_PER_S     1000
`define TPH_INIT_MS      200

// ************************************************************
// Scan rates in frames per second
// ************************************************************
`define TPH_ACT_FPS      8'h64
`define TPH_MON_FPS      8'h19

// ************************************************************
// Operating modes
// ************************************************************
`define TPH_MODE_ACTIVE  2'h0
`define TPH_MODE_MONITOR 2'h1
`define TPH_MODE_HIBER   2'h2

// ************************************************************
// Host visible byte map and bus address
// ************************************************************
`define TPH_REG_MODE     4'h0
`define TPH_REG_ACT_RATE 4'h1
`define TPH_REG_MON_RATE 4'h2
`define TPH_REG_TOUCH    4'h3
`define TPH_I2C_ADDR     7'h2a
`define TPH_BITS_BYTE    4'h8

`endif

// *** tph_mem.v ***
// Small byte memory holding host written parameters, registered read
`timescale 1ns/1ps
`default_nettype none

module tph_mem #(
  parameter AW = 4,
  parameter DW = 8
) (
  input  wire          i_sys_clk,
  input  wire          i_reset,
  input  wire          i_wr_en,
  input  wire [AW-1:0] i_wr_addr,
  input  wire [DW-1:0] i_wr_data,
  input  wire [AW-1:0] i_rd_addr,
  output reg  [DW-1:0] o_rd_data
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // ************************************************************
  // Write port
  // ************************************************************
  always @(posedge i_sys_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  // ************************************************************
  // Registered read port
  // ************************************************************
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rd_data <= {DW{1'b0}};
    end else begin
      o_rd_data <= mem[i_rd_addr];
    end
  end

endmodule // tph_mem

`default_nettype wire

// *** tph_i2c_host.sv ***
// Behavioural I2C controller standing in for the host processor
`timescale 1ns/1ps
`default_nettype none

module tph_i2c_host (
  input  wire logic i_sys_clk,
  input  wire logic i_sda,
  output var  logic o_scl,
  output var  logic o_sda_low
);
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  // SCL period of 16 clocks, data set mid low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    tick(4);
    o_sda_low = !b;
    tick(4);
    o_scl = 1'b1;
    tick(4);
    r = i_sda;
    tick(4);
    o_scl = 1'b0;
  endtask

  // Start, also a repeated start when SCL is low
  task automatic start();
    tick(4);
    o_sda_low = 1'b0;
    tick(4);
    o_scl = 1'b1;
    tick(8);
    o_sda_low = 1'b1;
    tick(8);
    o_scl = 1'b0;
  endtask

  task automatic stop();
    tick(4);
    o_sda_low = 1'b1;
    tick(4);
    o_scl = 1'b1;
    tick(8);
    o_sda_low = 1'b0;
    tick(8);
  endtask

  task automatic wbyte(input logic [7:0] d, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, nack);
  endtask

  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule // tph_i2c_host

`default_nettype wire

// *** tph_host_if_assertions.sv ***
// Concurrent checks on the ports of the host interface block
`timescale 1ns/1ps
`default_nettype none
`include "tph_defines.vh"

module tph_host_if_assertions (
  input wire logic       i_sys_clk,
  input wire logic       i_reset,
  input wire logic       i_chip_reset_n,
  input wire logic       i_frame_done,
  input wire logic       i_touch_found,
  input wire logic       o_sda,
  input wire logic       o_sda_oe,
  input wire logic       o_int_n,
  input wire logic       o_scan_start,
  input wire logic       o_presence_only,
  input wire logic       o_power_down,
  input wire logic [1:0] o_mode,
  input wire logic       o_cfg_wr
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);

  // Cycles since the pin reset was last seen low
  logic [3:0] quiet;
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) quiet <= 4'h0;
    else if (!i_chip_reset_n) quiet <= 4'h0;
    else if (quiet != 4'hf) quiet <= quiet + 4'h1;
  end

  AST_SDA_LOW_ONLY: assert property (o_sda_oe |-> o_sda == 1'b0)
    else $error("sda driven high");
  AST_SCAN_PULSE: assert property (o_scan_start |=> !o_scan_start)
    else $error("scan start too long");
  AST_HIBER_SCAN: assert property (o_power_down |-> !o_scan_start)
    else $error("scan in hibernate");
  AST_CFG_PULSE: assert property (o_cfg_wr |=> !o_cfg_wr)
    else $error("cfg write too long");
  AST_INT_SET: assert property ($fell(o_int_n) |-> $past(i_frame_done, 2) &&
    $past(i_touch_found, 2) && $past(o_mode, 2) == `TPH_MODE_ACTIVE)
    else $error("interrupt without touch");
  AST_PRESENCE: assert property (quiet == 4'hf |->
    o_presence_only == ($past(o_mode) == `TPH_MODE_MONITOR))
    else $error("presence flag wrong");
  AST_POWER: assert property (quiet == 4'hf |->
    o_power_down == ($past(o_mode) == `TPH_MODE_HIBER))
    else $error("power down flag wrong");
  AST_WAKE: assert property (o_mode == `TPH_MODE_MONITOR && i_frame_done &&
    i_touch_found |=> o_mode == `TPH_MODE_ACTIVE)
    else $error("no wake on touch");
  AST_PIN_RESET: assert property (!i_chip_reset_n [*6] |=>
    o_mode == `TPH_MODE_ACTIVE && o_int_n && !o_power_down)
    else $error("pin reset ignored");

  cover property (o_mode == `TPH_MODE_MONITOR ##1 o_mode == `TPH_MODE_ACTIVE);
  cover property ($fell(o_int_n));
  cover property (o_power_down);
endmodule // tph_host_if_assertions

bind tph_host_if tph_host_if_assertions chk_u (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_chip_reset_n(i_chip_reset_n),
  .i_frame_done(i_frame_done), .i_touch_found(i_touch_found), .o_sda(o_sda),
  .o_sda_oe(o_sda_oe), .o_int_n(o_int_n), .o_scan_start(o_scan_start),
  .o_presence_only(o_presence_only), .o_power_down(o_power_down),
  .o_mode(o_mode), .o_cfg_wr(o_cfg_wr)
);

`default_nettype wire

// *** testbench.sv ***
// Self-checking bench of the host interface block
`timescale 1ns/1ps
`default_nettype none
`include "tph_defines.vh"

module testbench;
  localparam int         INIT = 20;
  localparam int         HZ   = 100000;
  localparam logic [6:0] ADR  = `TPH_I2C_ADDR;
  logic        i_sys_clk = 1'b0;
  logic        rst;
  logic        pin_n;
  logic        frm;
  logic        tch;
  logic  [7:0] tdat;
  logic        scl, sda_low, sda, sda_out, sda_oe, int_n, scan, pres, pdown, cfg_wr;
  logic  [1:0] mode;
  logic  [3:0] cfg_addr;
  logic  [7:0] cfg_data;
  logic [11:0] notes [$];
  int          seed = 32'h1e1f3682;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;

  always #5 i_sys_clk = ~i_sys_clk;
  assign sda = !(sda_low || (sda_oe && !sda_out));

  tph_i2c_host host_u (.i_sys_clk(i_sys_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

  tph_host_if #(.CLK_HZ(HZ), .INIT_CYCLES(INIT)) dut_u (
    .i_sys_clk(i_sys_clk), .i_reset(rst), .i_chip_reset_n(pin_n), .i_scl(scl),
    .i_sda(sda), .o_sda(sda_out), .o_sda_oe(sda_oe), .o_int_n(int_n),
    .i_frame_done(frm), .i_touch_found(tch), .i_touch_data(tdat), .o_scan_start(scan),
    .o_presence_only(pres), .o_power_down(pdown), .o_mode(mode), .o_cfg_wr(cfg_wr),
    .o_cfg_addr(cfg_addr), .o_cfg_data(cfg_data));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d, output logic ack);
    logic nk;
    host_u.start();
    host_u.wbyte({ADR, 1'b0}, nk);
    ack = !nk;
    if (ack) begin
      notes.push_back({ptr[3:0], d});
      host_u.wbyte(ptr, nk);
      host_u.wbyte(d, nk);
    end
    host_u.stop();
  endtask

  task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
    logic nk;
    host_u.start();
    host_u.wbyte({ADR, 1'b0}, nk);
    host_u.wbyte(ptr, nk);
    host_u.start();
    host_u.wbyte({ADR, 1'b1}, nk);
    host_u.rbyte(1'b1, d);
    host_u.stop();
  endtask

  // Cycles between two scan starts
  task automatic gap(output int n);
    for (n = 0; n < 9000 && scan !== 1'b1; n++) host_u.tick(1);
    host_u.tick(1);
    for (n = 1; n < 9000 && scan !== 1'b1; n++) host_u.tick(1);
  endtask

  task automatic frame(input logic t);
    frm  = 1'b1;
    tch  = t;
    tdat = 8'($random(seed));
    host_u.tick(1);
    frm  = 1'b0;
    tch  = 1'($random(seed));
  endtask

  always @(negedge i_sys_clk) begin
    if (cfg_wr === 1'b1) begin
      if (notes.size() == 0) chk({4'h0, cfg_addr, cfg_data}, 16'hffff);
      else chk({4'h0, cfg_addr, cfg_data}, {4'h0, notes.pop_front()});
    end
  end

  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      end_sim();
    end
  end

  initial begin
    logic [7:0] mem [16];
    logic [7:0] d;
    logic       ack;
    int         n;
    rst   = 1'b1;
    pin_n = 1'b1;
    frm   = 1'b0;
    tch   = 1'b0;
    tdat  = 8'h00;
    repeat (10) @(posedge i_sys_clk);
    #1 rst = 1'b0;
    host_u.tick(INIT + 10);
    chk(16'(mode), 16'(`TPH_MODE_ACTIVE));
    chk(16'(int_n), 16'h1);
    $display("test reset finished");
    gap(n);
    chk(16'(n), 16'(HZ / 100));
    wr(8'h01, 8'h32, ack);
    gap(n);
    chk(16'(n), 16'(HZ / 50));
    wr(8'h01, 8'h64, ack);
    host_u.start();
    host_u.wbyte({ADR ^ 7'h01, 1'b0}, ack);
    host_u.stop();
    chk(16'(ack), 16'h1);
    wr(8'h00, 8'h03, ack);
    host_u.tick(2);
    chk(16'(mode), 16'(`TPH_MODE_ACTIVE));
    $display("test scan rate and address finished");
    for (int i = 4; i < 16; i++) begin
      mem[i] = 8'($random(seed));
      wr(8'(i), mem[i], ack);
      chk(16'(ack), 16'h1);
    end
    for (int i = 4; i < 16; i++) begin
      rd(8'(i), d);
      chk(16'(d), 16'(mem[i]));
    end
    $display("test parameters finished");
    frame(1'b0);
    host_u.tick(2);
    chk(16'(int_n), 16'h1);
    frame(1'b1);
    host_u.tick(2);
    chk(16'(int_n), 16'h0);
    rd(8'h03, d);
    chk(16'(d), 16'(tdat));
    host_u.tick(3);
    chk(16'(int_n), 16'h1);
    $display("test touch finished");
    wr(8'h00, 8'(`TPH_MODE_MONITOR), ack);
    host_u.tick(2);
    chk(16'(pres), 16'h1);
    gap(n);
    chk(16'(n), 16'(HZ / 25));
    wr(8'h04, 8'h5a, ack);
    chk(16'(ack), 16'h0);
    frame(1'b1);
    host_u.tick(1);
    chk(16'(mode), 16'(`TPH_MODE_ACTIVE));
    wr(8'h02, 8'h32, ack);
    wr(8'h00, 8'(`TPH_MODE_MONITOR), ack);
    gap(n);
    chk(16'(n), 16'(HZ / 50));
    frame(1'b1);
    host_u.tick(1);
    chk(16'(mode), 16'(`TPH_MODE_ACTIVE));
    $display("test monitor finished");
    wr(8'h00, 8'(`TPH_MODE_HIBER), ack);
    host_u.tick(2);
    chk(16'(pdown), 16'h1);
    frame(1'b1);
    wr(8'h00, 8'h00, ack);
    chk(16'(ack), 16'h0);
    pin_n = 1'b0;
    host_u.tick(6);
    pin_n = 1'b1;
    host_u.tick(8);
    chk(16'(mode), 16'(`TPH_MODE_ACTIVE));
    chk(16'(pdown), 16'h0);
    frame(1'b1);
    host_u.tick(3);
    chk(16'(int_n), 16'h1);
    $display("test hibernate finished");
    end_sim();
  end
endmodule // testbench

`default_nettype wire
